// [hdl/eeprom_rd_slave.v]
// Two-wire serial slave for reading an on-chip data EEPROM
`timescale 1ns/100ps
`include "eeprom_rd_defs.vh"

// Functional notes
// R1 - Bus idle only while clock and data both high; transfers start from idle.
// R2 - Data falling while clock high is START; every command starts with it.
// R3 - Data rising while clock high is STOP; every operation ends with it.
// R4 - Data change during clock high is a condition, never a data bit.
// R5 - Transmitter changes data only while clock low; one bit per pulse.
// R6 - Master sets byte count between START and STOP; slave imposes no limit; code refuses write data bytes while its two-entry buffer is full.
// R7 - Addressed receiver acknowledges each byte on a ninth clock pulse.
// R8 - No acknowledge driven while an internal programming cycle runs.
// R9 - Acknowledge holds data low for the whole high phase of its pulse.
// R10 - Master nack ends a read; slave releases data high for STOP.
// R11 - Read starts like a write with read/write bit set to one.
// R12 - Address counter holds last location plus one for current reads.
// R13 - Current read: ack read address, send one byte, stop on nack.
// R14 - Random read: word address loaded even when write is cut by START.
// R15 - After repeated START, read address acked, byte sent, counter advanced.
// R16 - Master ack on a data byte makes slave send next byte.
// R17 - Pointer advances by one at each completed read byte; code advances it as each byte is loaded.
// R18 - Ignore bus until START; return idle on STOP or master nack.
module eeprom_rd_slave
(
  input wire i_mclk, // System clock 50 MHz
  input wire i_reset_n, // Synchronous reset, active low
  input wire i_scl, // Serial clock pin
  input wire i_sda, // Serial data pin level
  output reg o_sda, // Serial data output value, always low
  output reg o_sda_oe, // High while slave pulls data low
  input wire i_prog_busy, // Programming cycle in progress
  input wire i_mem_wr, // Memory load strobe from core
  input wire [`EE_ADDR_W-1:0] i_mem_waddr, // Memory load address
  input wire [7:0] i_mem_wdata, // Memory load data
  output reg o_wr_valid, // Written byte available
  input wire i_wr_ready, // Core accepts written byte
  output reg [7:0] o_wr_data, // Written byte
  output reg [`EE_ADDR_W-1:0] o_wr_addr, // Address of written byte
  output reg [`EE_ADDR_W-1:0] o_ptr // Current address counter
);

  reg scl_m;
  reg scl_s;
  reg scl_d;
  reg sda_m;
  reg sda_s;
  reg sda_d;
  reg [2:0] state;
  reg [1:0] phase;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg read_mode;
  reg [7:0] mem [0:`EE_DEPTH-1];
  // Two-entry buffer for bytes received in write phase
  reg [7:0] buf_data [0:1];
  reg [`EE_ADDR_W-1:0] buf_addr [0:1];
  reg [1:0] buf_cnt;
  reg buf_rd;
  reg buf_wr;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire buf_push;
  wire buf_pop;
  wire buf_full;
  reg [7:0] next_shift;
  genvar gi;
  // Byte engine states, plain binary codes
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RX = 3'h1;
  localparam [2:0] ST_ACK = 3'h2;
  localparam [2:0] ST_TX = 3'h3;
  localparam [2:0] ST_MACK = 3'h4;

  // Pin synchronisers; first stage read only by second
  // Reset to the idle high level so no false edge follows reset
  always @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_m <= i_scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= i_sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // Edges of the sampled link clock and bus conditions
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s; // R2 R4
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s; // R3 R4

  // Buffer handshake; a full buffer refuses the data byte by withholding ack
  assign buf_full = (buf_cnt == 2'h2);
  assign buf_pop = (!o_wr_valid || i_wr_ready) && buf_cnt != 2'h0;
  assign buf_push = scl_fall && state == ST_RX && bit_cnt == 4'h8 && phase == `EE_PH_WDATA &&
    !buf_full && !i_prog_busy;

  // Next byte to shift out, loaded from the counter location
  always @*
  begin
    next_shift = mem[o_ptr];
  end

  // Main byte engine, stepping on sampled clock edges
  always @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      state <= ST_IDLE;
      phase <= `EE_PH_CTRL;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      read_mode <= 1'b0;
      o_ptr <= `EE_PTR_RST;
      o_sda <= 1'b0;
      o_sda_oe <= 1'b0;
    end
    else if (stop_det)
    begin
      // STOP wins over everything, even in mid-byte
      state <= ST_IDLE; // R18 R3
      o_sda_oe <= 1'b0;
    end
    else if (start_det)
    begin
      // Repeated START also aborts a write; pointer already loaded
      state <= ST_RX; // R2 R14 R18
      phase <= `EE_PH_CTRL;
      bit_cnt <= 4'h0;
      o_sda_oe <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          // Bus ignored until a START
          o_sda_oe <= 1'b0; // R18 R1
        end
        ST_RX:
        begin
          if (scl_rise)
          begin
            shift <= {shift[6:0], sda_s}; // R5
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == 4'h8)
          begin
            // Any refused byte drops back to idle with data released
            bit_cnt <= 4'h0;
            state <= ST_IDLE;
            case (phase)
              `EE_PH_CTRL:
              begin
                if (shift[7:1] == `EE_DEV_ID && !i_prog_busy) // R8
                begin
                  read_mode <= shift[0]; // R11
                  state <= ST_ACK;
                  o_sda_oe <= 1'b1; // R7 R9
                end
              end
              `EE_PH_WADDR:
              begin
                // A busy memory stays deaf: no ack, pointer kept
                if (!i_prog_busy) // R8
                begin
                  o_ptr <= shift[`EE_ADDR_W-1:0]; // R14
                  state <= ST_ACK;
                  o_sda_oe <= 1'b1; // R7
                end
              end
              `EE_PH_WDATA:
              begin
                // A full buffer refuses the byte rather than lose it
                if (!buf_full && !i_prog_busy) // R8
                begin
                  o_ptr <= o_ptr + 1'b1; // R12
                  state <= ST_ACK;
                  o_sda_oe <= 1'b1; // R7
                end
              end
              default:
              begin
                state <= ST_IDLE;
              end
            endcase
          end
        end
        ST_ACK:
        begin
          // Hold low through the whole ninth high phase
          if (scl_fall) // R9
          begin
            if (phase == `EE_PH_CTRL && read_mode)
            begin
              // First bit of the byte goes out as the ack pulse ends
              state <= ST_TX; // R13 R15
              shift <= {next_shift[6:0], 1'b0};
              o_sda_oe <= ~next_shift[7]; // R5
              bit_cnt <= 4'h1;
              o_ptr <= o_ptr + 1'b1; // R17 R12
            end
            else
            begin
              state <= ST_RX;
              phase <= (phase == `EE_PH_CTRL) ? `EE_PH_WADDR : `EE_PH_WDATA;
              o_sda_oe <= 1'b0;
            end
          end
        end
        ST_TX:
        begin
          // Bits change only after a sampled falling edge
          if (scl_fall)
          begin
            if (bit_cnt == 4'h8)
            begin
              state <= ST_MACK;
              o_sda_oe <= 1'b0; // R10
            end
            else
            begin
              o_sda_oe <= ~shift[7]; // R5
              shift <= {shift[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        ST_MACK:
        begin
          // Master ack sampled on the ninth rising edge
          if (scl_rise)
          begin
            if (sda_s)
            begin
              state <= ST_IDLE; // R10 R18
            end
            else
            begin
              state <= ST_TX; // R16 R6
              bit_cnt <= 4'h0;
            end
          end
          else if (scl_fall)
          begin
            o_sda_oe <= 1'b0;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
      // Start next byte of a sequential read on the falling edge
      // Counter moves as each byte is loaded, so a cut read still advances
      if (state == ST_TX && bit_cnt == 4'h0 && scl_fall)
      begin
        shift <= {next_shift[6:0], 1'b0};
        o_sda_oe <= ~next_shift[7]; // R16
        bit_cnt <= 4'h1;
        o_ptr <= o_ptr + 1'b1; // R17
      end
    end
  end

  // Memory image, loaded by the core
  // Not reset: content stays the core's to load
  always @(posedge i_mclk)
  begin
    if (i_mem_wr)
    begin
      mem[i_mem_waddr] <= i_mem_wdata;
    end
  end

  // Buffer entries, one generate slot per entry
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_buf
      always @(posedge i_mclk)
      begin
        // Entry chosen by the write index
        if (buf_push && {31'h0, buf_wr} == gi)
        begin
          buf_data[gi] <= shift;
          buf_addr[gi] <= o_ptr;
        end
      end
    end
  endgenerate

  // Buffer pointers and registered output stage
  always @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      buf_cnt <= 2'h0;
      buf_rd <= 1'b0;
      buf_wr <= 1'b0;
      o_wr_valid <= 1'b0;
      o_wr_data <= 8'h00;
      o_wr_addr <= `EE_PTR_RST;
    end
    else
    begin
      if (buf_push)
      begin
        buf_wr <= ~buf_wr;
      end
      // Output register is a third place behind the two entries
      if (!o_wr_valid || i_wr_ready)
      begin
        o_wr_valid <= (buf_cnt != 2'h0);
      end
      // Only a real entry is copied, so the output never shows stale data
      if (buf_pop)
      begin
        o_wr_data <= buf_data[buf_rd];
        o_wr_addr <= buf_addr[buf_rd];
        buf_rd <= ~buf_rd;
      end
      buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

endmodule

// [hdl/eeprom_rd_defs.vh]
// Constants for the two-wire EEPROM read slave
`ifndef EEPROM_RD_DEFS_VH
`define EEPROM_RD_DEFS_VH
`define EE_ADDR_W 4
`define EE_DEPTH 16
`define EE_DEV_ID 7'h50
`define EE_PTR_RST 4'h0
`define EE_PH_CTRL 2'h0
`define EE_PH_WADDR 2'h1
`define EE_PH_WDATA 2'h2
`endif

// [dv/eeprom_rd_slave_monitor.sv]
// Checker for the two-wire EEPROM read slave ports
`timescale 1ns/100ps
`include "eeprom_rd_defs.vh"
module eeprom_rd_slave_monitor
(
  input wire i_mclk, // Clock
  input wire i_reset_n, // Reset, active low
  input wire i_scl, // Bus clock
  input wire i_sda, // Bus data
  input wire o_sda, // Data out value
  input wire o_sda_oe, // Data pull enable
  input wire i_prog_busy, // Programming busy
  input wire o_wr_valid, // Buffer valid
  input wire i_wr_ready, // Buffer ready
  input wire [7:0] o_wr_data, // Buffer data
  input wire [`EE_ADDR_W-1:0] o_ptr // Address counter
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // Open drain: only a low level is ever driven
  AST_SDA_LOW: assert property (o_sda_oe |-> o_sda == 1'b0) else $error("data driven high");
  AST_OE_SCL_LOW: assert property (!$stable(o_sda_oe) |-> !i_scl) else $error("data moved in clock high");
  AST_ACK_WHOLE: assert property (o_sda_oe && $rose(i_scl) |-> o_sda_oe [*5]) else $error("pull dropped");
  AST_OE_LEN: assert property ($rose(o_sda_oe) |-> o_sda_oe [*6]) else $error("pull too short");
  AST_NO_ACK_BUSY: assert property ($rose(o_sda_oe) |-> !$past(i_prog_busy)) else $error("ack while busy");
  AST_STOP_IDLE: assert property (i_scl && $past(i_scl) && $rose(i_sda) |=> !o_sda_oe [*8])
    else $error("drive after stop");
  AST_VALID_HOLD: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_data))
    else $error("word lost");
  AST_RESET: assert property (disable iff (1'b0) !i_reset_n |=> !o_sda_oe && !o_wr_valid && o_ptr == `EE_PTR_RST)
    else $error("reset value");
  // Main scenarios reached
  COV_ACK: cover property ($rose(o_sda_oe));
  COV_WORD: cover property ($rose(o_wr_valid));
  COV_PTR: cover property (!$stable(o_ptr));
endmodule
bind eeprom_rd_slave eeprom_rd_slave_monitor mon (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_scl(i_scl),
  .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_prog_busy(i_prog_busy), .o_wr_valid(o_wr_valid),
  .i_wr_ready(i_wr_ready), .o_wr_data(o_wr_data), .o_ptr(o_ptr));

// [dv/bus_master_model.sv]
// Two-wire bus master model, 160 ns clock that stands high outside frames
`timescale 1ns/100ps
module bus_master_model
(
  input wire i_sda, // Resolved data line
  output reg o_scl, // Bus clock
  output reg o_sda_oe // High while master pulls data low
);
  initial
  begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  // Data set in clock low, sampled late in clock high
  task bit_io(input logic b, output logic r);
  begin
    o_sda_oe = ~b;
    #40 o_scl = 1'b1;
    #80 r = i_sda;
    o_scl = 1'b0;
    #40;
  end
  endtask
  // Also serves as repeated start for a random read
  task start;
  begin
    o_sda_oe = 1'b0;
    #40 o_scl = 1'b1;
    #80 o_sda_oe = 1'b1;
    #80 o_scl = 1'b0;
    #40;
  end
  endtask
  task stop;
  begin
    o_sda_oe = 1'b1;
    #40 o_scl = 1'b1;
    #80 o_sda_oe = 1'b0;
    #80;
  end
  endtask
  // MSB first, ninth pulse for the acknowledge
  task wbyte(input logic [7:0] d, output logic ack);
    integer i;
    logic r;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  end
  endtask
  task rbyte(input logic mack, output logic [7:0] d);
    integer i;
    logic r;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bit_io(1'b1, d[i]);
    bit_io(~mack, r);
  end
  endtask
endmodule

// [dv/eeprom_rd_slave_tb_top.sv]
// Self-checking bench for the two-wire EEPROM read slave
`timescale 1ns/100ps
`include "eeprom_rd_defs.vh"
module eeprom_rd_slave_tb_top;
  reg i_mclk = 1'b0;
  reg i_reset_n = 1'b0;
  reg i_prog_busy = 1'b0;
  reg i_mem_wr = 1'b0;
  reg [3:0] i_mem_waddr = 4'h0;
  reg [7:0] i_mem_wdata = 8'h00;
  reg i_wr_ready = 1'b0;
  wire scl, m_oe, o_sda, o_sda_oe, o_wr_valid;
  wire [7:0] o_wr_data;
  wire [3:0] o_wr_addr, o_ptr;
  // Pull-up resolves the open-drain line
  wire sda = ~m_oe & (o_sda_oe ? o_sda : 1'b1);
  integer fails = 0;
  integer checks_done = 0;
  integer k;
  logic a;
  logic [7:0] d;
  always #10 i_mclk = ~i_mclk;
  eeprom_rd_slave dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_scl(scl), .i_sda(sda), .o_sda(o_sda),
    .o_sda_oe(o_sda_oe), .i_prog_busy(i_prog_busy), .i_mem_wr(i_mem_wr), .i_mem_waddr(i_mem_waddr),
    .i_mem_wdata(i_mem_wdata), .o_wr_valid(o_wr_valid), .i_wr_ready(i_wr_ready), .o_wr_data(o_wr_data),
    .o_wr_addr(o_wr_addr), .o_ptr(o_ptr));
  bus_master_model m (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
  // Memory pattern: high nibble address, low nibble its inverse
  function logic [7:0] ev(input logic [3:0] x);
    ev = {x, ~x};
  endfunction
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
  begin
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task rand_seq;
  begin
    m.start;
    m.wbyte(8'ha0, a);
    m.wbyte(8'h0e, a);
    m.start;
    m.wbyte(8'ha1, a);
    chk("read ack", 8'h01, {7'h0, a});
    for (k = 0; k < 3; k = k + 1)
    begin
      m.rbyte(k < 2, d);
      chk("seq data", ev(4'he + k[3:0]), d);
    end
    m.stop;
    chk("ptr", 8'h01, {4'h0, o_ptr});
    $display("done rand_seq");
  end
  endtask
  task cur_rd;
  begin
    m.start;
    m.wbyte(8'ha1, a);
    m.rbyte(1'b0, d);
    m.stop;
    chk("cur data", ev(4'h1), d);
    chk("cur ptr", 8'h02, {4'h0, o_ptr});
    $display("done cur_rd");
  end
  endtask
  task refuse;
  begin
    i_prog_busy = 1'b1;
    m.start;
    m.wbyte(8'ha1, a);
    m.stop;
    chk("busy ack", 8'h00, {7'h0, a});
    i_prog_busy = 1'b0;
    m.start;
    m.wbyte(8'ha0, a);
    chk("idle ctrl ack", 8'h01, {7'h0, a});
    i_prog_busy = 1'b1;
    m.wbyte(8'h0a, a);
    m.stop;
    chk("busy addr ack", 8'h00, {7'h0, a});
    chk("busy ptr", 8'h02, {4'h0, o_ptr});
    i_prog_busy = 1'b0;
    m.start;
    m.wbyte(8'ha3, a);
    m.stop;
    chk("bad id ack", 8'h00, {7'h0, a});
    $display("done refuse");
  end
  endtask
  task wr_buf;
  begin
    m.start;
    m.wbyte(8'ha0, a);
    m.wbyte(8'h05, a);
    m.wbyte(8'h5a, a);
    m.wbyte(8'hc3, a);
    chk("second ack", 8'h01, {7'h0, a});
    m.wbyte(8'h3c, a);
    chk("third ack", 8'h01, {7'h0, a});
    m.wbyte(8'h96, a);
    chk("full ack", 8'h00, {7'h0, a});
    m.stop;
    chk("wr ptr", 8'h08, {4'h0, o_ptr});
    @(negedge i_mclk);
    i_wr_ready = 1'b1;
    for (k = 0; k < 3; k = k + 1)
    begin
      chk("valid", 8'h01, {7'h0, o_wr_valid});
      chk("wr data", (k == 0) ? 8'h5a : (k == 1) ? 8'hc3 : 8'h3c, o_wr_data);
      chk("wr addr", 8'h05 + k[7:0], {4'h0, o_wr_addr});
      @(negedge i_mclk);
    end
    chk("empty", 8'h00, {7'h0, o_wr_valid});
    $display("done wr_buf");
  end
  endtask
  initial
  begin
    repeat (2) @(negedge i_mclk);
    i_reset_n = 1'b1;
    for (k = 0; k < 16; k = k + 1)
    begin
      @(negedge i_mclk);
      i_mem_wr = 1'b1;
      i_mem_waddr = k[3:0];
      i_mem_wdata = ev(k[3:0]);
    end
    @(negedge i_mclk);
    i_mem_wr = 1'b0;
    rand_seq;
    cur_rd;
    refuse;
    wr_buf;
    end_of_test;
  end
endmodule
